// [mcs_microstep_standby.sv]
module mcs_microstep_standby (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clkEn,
	// Standby and power
	input wire logic standby,
	output logic regulatorOn,
	output logic unitsOn,
	// Step and direction pins
	input wire logic stepIn,
	input wire logic dirIn,
	input wire logic drive_enable_n,
	input wire logic [1:0] msSel,
	// Coil drive and position
	output logic coilDriveEn,
	output logic [9:0] microstep_phase_count,
	output logic fullstep,
	output logic [31:0] position,
	// Single-wire link pin
	input wire logic uartIn,
	output logic uartOut,
	output logic uartOeN,
	// Accepted register writes
	output mcs_pkg::mcs_wr_t cfgWrite
);

	mcs_pkg::mcs_link_t s_q;
	mcs_pkg::mcs_link_t s_d;
	mcs_pkg::mcs_phase_t ph;
	mcs_pkg::mcs_mres_t mres;
	logic [31:0] rdData;
	logic [15:0] bt;
	logic [15:0] meas;
	logic [3:0] nb;
	logic [7:0] curByte;
	logic [7:0] addrByte;
	logic [55:0] txWord;
	logic fall;
	logic isRead;

	// Abort the datagram and wait for the line to stay idle
	function automatic mcs_pkg::mcs_link_t to_recover(input mcs_pkg::mcs_link_t x);
		mcs_pkg::mcs_link_t r;
		r = x;
		r.st = mcs_pkg::U_RECOVER;
		r.cnt = '0;
		r.gapBits = '0;
		r.byteIdx = '0;
		r.crc = '0;
		return r;
	endfunction

	// Register bits override the straps only when software asks for it
	assign mres = s_q.ctrl[mcs_pkg::CTRL_PIN_OFF] ?
		mcs_pkg::mcs_mres_t'(s_q.ctrl[mcs_pkg::CTRL_MRES_LSB +: 2]) : mcs_pkg::mcs_mres_t'(msSel);

	mcs_phase_counter u_phase (
		.clock(clock),
		.rst(rst),
		.clkEn(clkEn),
		.clear(standby),
		.stepIn(stepIn),
		.dirIn(dirIn),
		.mres(mres),
		.phaseState(ph)
	);

	// Power state: the regulator and all units follow the standby pin directly
	assign regulatorOn = !standby;
	assign unitsOn = !standby;
	// Coils stay off in standby whatever the enable pin does
	assign coilDriveEn = !standby && !drive_enable_n;
	assign microstep_phase_count = ph.phase;
	assign fullstep = ph.fullstep;
	assign position = ph.pos;
	assign uartOut = s_q.txBit;
	assign uartOeN = s_q.txOeN;
	assign cfgWrite = s_q.wr;

	// Read mux, unmapped addresses answer zero
	always_comb begin
		unique case (s_q.rdAddr)
			mcs_pkg::REG_CTRL: rdData = {29'h00000000, s_q.ctrl};
			mcs_pkg::REG_WRCOUNT: rdData = {24'h000000, s_q.wrCount};
			mcs_pkg::REG_PHASE: rdData = {22'h000000, ph.phase};
			mcs_pkg::REG_POSITION: rdData = ph.pos;
			default: rdData = 32'h00000000;
		endcase
	end

	// Link sequencer: sync measure, receive, check, reply
	always_comb begin
		s_d = s_q;
		s_d.wr.valid = 1'b0;
		s_d.lineQ = uartIn;
		fall = s_q.lineQ && !uartIn;
		// Guard against an unmeasured bit time during recovery
		bt = (s_q.bitClks < mcs_pkg::MIN_BIT_CLKS) ? mcs_pkg::MIN_BIT_CLKS : s_q.bitClks;
		meas = 16'((s_q.cnt + 18'h00001) >> 2);
		nb = s_q.bitIdx + 4'h1;
		curByte = s_q.tx[63:56];
		isRead = (s_q.byteIdx == 3'h3) && !s_q.frame[7];
		addrByte = isRead ? s_q.frame[15:8] : s_q.frame[47:40];
		txWord = {mcs_pkg::SYNC_BYTE, mcs_pkg::REPLY_ADDR, 1'b0, s_q.rdAddr, rdData};
		unique case (s_q.st)
			mcs_pkg::U_IDLE: begin
				if (fall) begin
					s_d.gapBits = '0;
					if (s_q.byteIdx == 3'h0) begin
						s_d.st = mcs_pkg::U_SYNC;
						s_d.cnt = '0;
						s_d.falls = 1'b0;
					end else begin
						s_d.st = mcs_pkg::U_DATA;
						s_d.bitIdx = '0;
						s_d.cnt = 18'(bt) + 18'(bt >> 1) - 18'h00001;
					end
				end else if (s_q.byteIdx != 3'h0) begin
					// Pause between bytes of one datagram is bounded
					if (s_q.cnt == 18'(bt - 16'h0001)) begin
						s_d.cnt = '0;
						s_d.gapBits = s_q.gapBits + 6'h01;
						if (s_q.gapBits == mcs_pkg::GAP_BITS - 6'h01) begin
							s_d = to_recover(s_q);
						end
					end else begin
						s_d.cnt = s_q.cnt + 18'h00001;
					end
				end
			end
			mcs_pkg::U_SYNC: begin
				s_d.cnt = s_q.cnt + 18'h00001;
				if (fall) begin
					if (!s_q.falls) begin
						s_d.falls = 1'b1;
					end else if (meas < mcs_pkg::MIN_BIT_CLKS) begin
						s_d = to_recover(s_q); // Too short: a glitch, not a sync
					end else begin
						s_d.bitClks = meas;
						s_d.st = mcs_pkg::U_DATA;
						s_d.bitIdx = 4'h3;
						s_d.rxByte = mcs_pkg::SYNC_PRELOAD;
						s_d.cnt = 18'(meas >> 1) - 18'h00001;
					end
				end else if (&s_q.cnt) begin
					s_d = to_recover(s_q);
				end
			end
			mcs_pkg::U_DATA: begin
				if (s_q.cnt == '0) begin
					s_d.rxByte = {uartIn, s_q.rxByte[7:1]};
					s_d.cnt = 18'(bt - 16'h0001);
					if (s_q.bitIdx == 4'h7) begin
						s_d.st = mcs_pkg::U_STOP;
					end else begin
						s_d.bitIdx = nb;
					end
				end else begin
					s_d.cnt = s_q.cnt - 18'h00001;
				end
			end
			mcs_pkg::U_STOP: begin
				if (s_q.cnt != '0) begin
					s_d.cnt = s_q.cnt - 18'h00001;
				end else if (!uartIn) begin
					s_d = to_recover(s_q);
				end else begin
					s_d.st = mcs_pkg::U_IDLE;
					s_d.cnt = '0;
					if (s_q.byteIdx == 3'h0 && s_q.rxByte[3:0] != mcs_pkg::SYNC_NIBBLE) begin
						s_d = to_recover(s_q);
					end else if (isRead || s_q.byteIdx == 3'h7) begin
						s_d.byteIdx = '0;
						s_d.crc = '0;
						// Bad CRC or other slave address: drop and resynchronise
						if (s_q.rxByte != s_q.crc || addrByte != {6'h00, msSel}) begin
							s_d = to_recover(s_q);
						end else if (isRead) begin
							s_d.st = mcs_pkg::U_TXWAIT;
							s_d.rdAddr = s_q.frame[6:0];
							s_d.bitIdx = '0;
							s_d.cnt = 18'(bt - 16'h0001);
						end else begin
							s_d.wr = '{valid: 1'b1, addr: s_q.frame[38:32], data: s_q.frame[31:0]};
							s_d.wrCount = s_q.wrCount + 8'h01;
							if (s_q.frame[38:32] == mcs_pkg::REG_CTRL) begin
								s_d.ctrl = s_q.frame[2:0];
							end
						end
					end else begin
						s_d.frame = {s_q.frame[47:0], s_q.rxByte};
						s_d.crc = mcs_pkg::crc8_byte(s_q.crc, s_q.rxByte);
						s_d.byteIdx = s_q.byteIdx + 3'h1;
					end
				end
			end
			mcs_pkg::U_RECOVER: begin
				if (!uartIn) begin
					s_d.cnt = '0;
					s_d.gapBits = '0;
				end else if (s_q.cnt == 18'(bt - 16'h0001)) begin
					s_d.cnt = '0;
					s_d.gapBits = s_q.gapBits + 6'h01;
					if (s_q.gapBits == mcs_pkg::RECOVER_BITS - 6'h01) begin
						s_d.st = mcs_pkg::U_IDLE;
						s_d.gapBits = '0;
					end
				end else begin
					s_d.cnt = s_q.cnt + 18'h00001;
				end
			end
			mcs_pkg::U_TXWAIT: begin
				// Turnaround pause lets the controller release the line
				if (s_q.cnt != '0) begin
					s_d.cnt = s_q.cnt - 18'h00001;
				end else if (s_q.bitIdx == mcs_pkg::SEND_DELAY_BITS - 4'h1) begin
					s_d.tx = {txWord, mcs_pkg::crc8_frame(txWord)};
					s_d.st = mcs_pkg::U_TX;
					s_d.bitIdx = '0;
					s_d.byteIdx = '0;
					s_d.txOeN = 1'b0;
					s_d.txBit = 1'b0;
					s_d.cnt = 18'(bt - 16'h0001);
				end else begin
					s_d.bitIdx = nb;
					s_d.cnt = 18'(bt - 16'h0001);
				end
			end
			mcs_pkg::U_TX: begin
				if (s_q.cnt != '0) begin
					s_d.cnt = s_q.cnt - 18'h00001;
				end else begin
					s_d.cnt = 18'(bt - 16'h0001);
					if (s_q.bitIdx == 4'h9) begin
						if (s_q.byteIdx == 3'h7) begin
							s_d.st = mcs_pkg::U_IDLE;
							s_d.txOeN = 1'b1;
							s_d.txBit = 1'b1;
							s_d.byteIdx = '0;
							s_d.cnt = '0;
						end else begin
							s_d.tx = {s_q.tx[55:0], 8'h00};
							s_d.byteIdx = s_q.byteIdx + 3'h1;
							s_d.bitIdx = '0;
							s_d.txBit = 1'b0;
						end
					end else begin
						s_d.bitIdx = nb;
						s_d.txBit = (nb == 4'h9) ? 1'b1 : curByte[3'(nb - 4'h1)];
					end
				end
			end
			default: s_d = mcs_pkg::LINK_RST;
		endcase
		// Standby holds everything at its power-up value, so waking restores defaults
		if (standby) begin
			s_d = mcs_pkg::LINK_RST;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= mcs_pkg::LINK_RST;
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

endmodule

// [mcs_pkg.sv]
package mcs_pkg;

	// Microstep resolution codes as strapped on the two select pins
	typedef enum logic [1:0] {
		MRES_8 = 2'b00,
		MRES_32 = 2'b01,
		MRES_64 = 2'b10,
		MRES_16 = 2'b11
	} mcs_mres_t;

	// Phase increment per step pulse, 256 divided by the resolution
	localparam logic [9:0] STEP_INC_8 = 10'h020;
	localparam logic [9:0] STEP_INC_16 = 10'h010;
	localparam logic [9:0] STEP_INC_32 = 10'h008;
	localparam logic [9:0] STEP_INC_64 = 10'h004;
	// Low byte of the phase at every fullstep: 128, 384, 640, 896
	localparam logic [7:0] FULLSTEP_LSB = 8'h80;

	// Single-wire link framing and timing, counted in bit times except MIN_BIT_CLKS, which is in clocks
	localparam logic [3:0] SYNC_NIBBLE = 4'h5;
	localparam logic [7:0] SYNC_BYTE = 8'h05;
	localparam logic [7:0] SYNC_PRELOAD = 8'ha0;
	localparam logic [7:0] REPLY_ADDR = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [15:0] MIN_BIT_CLKS = 16'h0010;
	localparam logic [5:0] GAP_BITS = 6'h3f;
	localparam logic [5:0] RECOVER_BITS = 6'h0c;
	localparam logic [3:0] SEND_DELAY_BITS = 4'h8;

	// Link register map
	localparam logic [6:0] REG_CTRL = 7'h00;
	localparam logic [6:0] REG_WRCOUNT = 7'h01;
	localparam logic [6:0] REG_PHASE = 7'h02;
	localparam logic [6:0] REG_POSITION = 7'h03;
	// Control register: bit 0 overrides the select pins, bits 2:1 give the resolution
	localparam int CTRL_PIN_OFF = 0;
	localparam int CTRL_MRES_LSB = 1;
	localparam logic [2:0] CTRL_RST = 3'h0;

	typedef enum logic [2:0] {
		U_IDLE = 3'b000,
		U_SYNC = 3'b001,
		U_DATA = 3'b010,
		U_STOP = 3'b011,
		U_RECOVER = 3'b100,
		U_TXWAIT = 3'b101,
		U_TX = 3'b110
	} mcs_ustate_t;

	// One accepted register write
	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [31:0] data;
	} mcs_wr_t;

	typedef struct packed {
		logic stepQ;
		logic [9:0] phase;
		logic [31:0] pos;
		logic fullstep;
	} mcs_phase_t;

	typedef struct packed {
		mcs_ustate_t st;
		logic [15:0] bitClks;
		logic [17:0] cnt;
		logic falls;
		logic [3:0] bitIdx;
		logic [2:0] byteIdx;
		logic [5:0] gapBits;
		logic [7:0] rxByte;
		logic [55:0] frame;
		logic [7:0] crc;
		logic [63:0] tx;
		logic txBit;
		logic txOeN;
		logic lineQ;
		logic [6:0] rdAddr;
		mcs_wr_t wr;
		logic [7:0] wrCount;
		logic [2:0] ctrl;
	} mcs_link_t;

	localparam mcs_phase_t PHASE_RST = '{default: '0};
	localparam mcs_link_t LINK_RST = '{st: U_IDLE, txBit: 1'b1, txOeN: 1'b1, lineQ: 1'b1,
		ctrl: CTRL_RST, default: '0};

	// CRC over one byte, least significant bit first
	function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[7] ^ b[i]) begin
				r = {r[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[6:0], 1'b0};
			end
		end
		return r;
	endfunction

	// CRC over seven bytes, highest byte first as they go on the wire
	function automatic logic [7:0] crc8_frame(input logic [55:0] w);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 6; i >= 0; i--) begin
			c = crc8_byte(c, w[i*8 +: 8]);
		end
		return c;
	endfunction

endpackage

// [mcs_phase_counter.sv]
module mcs_phase_counter (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clkEn,
	// Standby clear
	input wire logic clear,
	// Step interface
	input wire logic stepIn,
	input wire logic dirIn,
	input wire mcs_pkg::mcs_mres_t mres,
	// Position
	output mcs_pkg::mcs_phase_t phaseState
);

	mcs_pkg::mcs_phase_t s_q;
	mcs_pkg::mcs_phase_t s_d;
	logic [9:0] inc;

	// Increment follows the live resolution
	always_comb begin
		unique case (mres)
			mcs_pkg::MRES_8: inc = mcs_pkg::STEP_INC_8;
			mcs_pkg::MRES_16: inc = mcs_pkg::STEP_INC_16;
			mcs_pkg::MRES_32: inc = mcs_pkg::STEP_INC_32;
			mcs_pkg::MRES_64: inc = mcs_pkg::STEP_INC_64;
		endcase
	end

	// Rising step edge moves phase and position; the 10-bit sum wraps by itself
	always_comb begin
		s_d = s_q;
		s_d.stepQ = stepIn;
		if (stepIn && !s_q.stepQ) begin
			if (!dirIn) begin
				s_d.phase = s_q.phase + inc;
				s_d.pos = s_q.pos + 32'h00000001;
			end else begin
				s_d.phase = s_q.phase - inc;
				s_d.pos = s_q.pos - 32'h00000001;
			end
		end
		s_d.fullstep = (s_d.phase[7:0] == mcs_pkg::FULLSTEP_LSB);
		if (clear) begin
			s_d = mcs_pkg::PHASE_RST;
		end
	end

	// Power-up starts from phase and position zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= mcs_pkg::PHASE_RST;
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	assign phaseState = s_q;

endmodule

// [mcs_check_monitor.sv]
module mcs_check_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clkEn,
	// Power and pins
	input wire logic standby,
	input wire logic regulatorOn,
	input wire logic unitsOn,
	input wire logic stepIn,
	input wire logic dirIn,
	input wire logic drive_enable_n,
	input wire logic [1:0] msSel,
	// Drive and position
	input wire logic coilDriveEn,
	input wire logic [9:0] microstep_phase_count,
	input wire logic fullstep,
	input wire logic [31:0] position,
	// Link
	input wire logic uartIn,
	input wire logic uartOut,
	input wire logic uartOeN,
	input wire mcs_pkg::mcs_wr_t cfgWrite
);
	logic prevStep;
	logic stepEv;
	logic [9:0] inc;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// Last sampled step level; standby holds it at zero like the counter does
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prevStep <= 1'b0;
		end else if (clkEn) begin
			prevStep <= stepIn & ~standby;
		end
	end

	// Expected increment from the straps
	always_comb begin
		case (msSel)
			2'h0: inc = mcs_pkg::STEP_INC_8;
			2'h1: inc = mcs_pkg::STEP_INC_32;
			2'h2: inc = mcs_pkg::STEP_INC_64;
			default: inc = mcs_pkg::STEP_INC_16;
		endcase
	end

	// A step is taken on a sampled rising level outside standby
	assign stepEv = stepIn & ~prevStep & clkEn & ~standby;

	regulator_off_a: assert property (standby |-> !regulatorOn && !unitsOn && !coilDriveEn)
	else $error("power still on in standby");
	standby_clear_a: assert property (standby && clkEn |=> microstep_phase_count == 10'h000 && position == 32'h0)
	else $error("state not cleared by standby");
	step_up_a: assert property (stepEv && !dirIn |=> microstep_phase_count == $past(microstep_phase_count) + $past(inc))
	else $error("phase did not rise by the increment");
	step_down_a: assert property (stepEv && dirIn |=> microstep_phase_count == $past(microstep_phase_count) - $past(inc))
	else $error("phase did not fall by the increment");
	position_step_a: assert property (stepEv |=> position == $past(position) + ($past(dirIn) ? 32'hffffffff : 32'h1))
	else $error("position did not follow the step");
	hold_still_a: assert property (!stepEv && !standby |=> $stable(microstep_phase_count) && $stable(position))
	else $error("phase moved without a step");
	fullstep_flag_a: assert property (fullstep == (microstep_phase_count[7:0] == mcs_pkg::FULLSTEP_LSB))
	else $error("fullstep flag disagrees with phase");
	idle_line_a: assert property (uartOeN |-> uartOut)
	else $error("line drive value not high while released");
	write_pulse_a: assert property (cfgWrite.valid |=> !cfgWrite.valid)
	else $error("write strobe longer than one cycle");
endmodule

bind mcs_microstep_standby mcs_check_monitor chk (.clock(clock), .rst(rst), .clkEn(clkEn), .standby(standby),
	.regulatorOn(regulatorOn), .unitsOn(unitsOn), .stepIn(stepIn), .dirIn(dirIn), .drive_enable_n(drive_enable_n),
	.msSel(msSel), .coilDriveEn(coilDriveEn), .microstep_phase_count(microstep_phase_count), .fullstep(fullstep),
	.position(position), .uartIn(uartIn), .uartOut(uartOut), .uartOeN(uartOeN), .cfgWrite(cfgWrite));

// [mcs_host_model.sv]
module mcs_host_model (
	// Clock
	input wire logic clock,
	// Step and direction pins
	output logic stepIn,
	output logic dirIn,
	// Shared serial line
	output logic hostTx,
	input wire logic line
);
	timeunit 1ns;
	timeprecision 1ns;

	// Bit time in clocks; the smallest the device accepts, so runs stay short
	localparam int BIT_CLKS = 16;

	// Pins idle low, the serial line idles high
	initial begin
		stepIn = 1'b0;
		dirIn = 1'b0;
		hostTx = 1'b1;
	end

	// Reference check byte, worked bit by bit, each byte least significant bit first
	function automatic logic [7:0] refCrc(input logic [55:0] w, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = n - 1; i >= 0; i--) begin
			for (int j = 0; j < 8; j++) begin
				c = (c[7] ^ w[i*8+j]) ? ({c[6:0], 1'b0} ^ mcs_pkg::CRC_POLY) : {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

	// Start bit, eight data bits least significant first, stop bit
	task automatic sendByte(input logic [7:0] b);
		hostTx = 1'b0;
		repeat (BIT_CLKS) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			hostTx = b[i];
			repeat (BIT_CLKS) @(negedge clock);
		end
		hostTx = 1'b1;
		repeat (BIT_CLKS) @(negedge clock);
	endtask

	// Datagram of n bytes, highest first, then its check byte, spoiled on request
	task automatic sendFrame(input logic [55:0] w, input int n, input logic badCrc);
		for (int i = n - 1; i >= 0; i--) begin
			sendByte(w[i*8 +: 8]);
		end
		sendByte(refCrc(w, n) ^ {7'h00, badCrc});
	endtask

	// Reply byte: find the start bit, then sample each bit near its middle
	task automatic recvByte(output logic [7:0] b, output logic stopBit);
		while (line !== 1'b0) begin
			@(negedge clock);
		end
		repeat (BIT_CLKS + BIT_CLKS / 2) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			b[i] = line;
			repeat (BIT_CLKS) @(negedge clock);
		end
		stopBit = line;
	endtask

	// One cycle high, one low per pulse; returns only with the motor stopped
	task automatic pulse(input int n, input logic d);
		dirIn = d;
		@(negedge clock);
		repeat (n) begin
			@(negedge clock);
			stepIn = 1'b1;
			@(negedge clock);
			stepIn = 1'b0;
		end
		@(negedge clock);
	endtask
endmodule

// [testbench.sv]
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst, standby, drive_enable_n, stepIn, dirIn;
	logic regulatorOn, unitsOn, coilDriveEn, fullstep, uartOut, uartOeN;
	logic [1:0] msSel;
	logic [9:0] phase;
	logic [31:0] position;
	mcs_pkg::mcs_wr_t cfgWrite;
	mcs_pkg::mcs_wr_t lastWr;
	logic hostTx;
	logic line;
	int wrSeen = 0;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	mcs_host_model host (.clock(clock), .stepIn(stepIn), .dirIn(dirIn), .hostTx(hostTx), .line(line));

	// One shared wire: whoever has the turn drives it
	assign line = uartOeN ? hostTx : uartOut;

	mcs_microstep_standby dut (.clock(clock), .rst(rst), .clkEn(1'b1), .standby(standby), .regulatorOn(regulatorOn),
		.unitsOn(unitsOn), .stepIn(stepIn), .dirIn(dirIn), .drive_enable_n(drive_enable_n), .msSel(msSel),
		.coilDriveEn(coilDriveEn), .microstep_phase_count(phase), .fullstep(fullstep), .position(position),
		.uartIn(line), .uartOut(uartOut), .uartOeN(uartOeN), .cfgWrite(cfgWrite));

	// Write strobe lasts one cycle, so catch it mid-cycle while it stands
	always @(negedge clock) begin
		if (cfgWrite.valid === 1'b1) begin
			lastWr = cfgWrite;
			wrSeen++;
		end
	end

	// Clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end

	task automatic results();
		$display("comparisons %0d, errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic tReset();
		`CHK({phase, position, fullstep}, 43'h0)
		`CHK({uartOut, uartOeN, cfgWrite.valid}, 3'b110)
	endtask

	// Enter and leave standby, trying to step while in it
	task automatic doStandby();
		@(negedge clock);
		standby = 1'b1;
		drive_enable_n = 1'b0;
		@(negedge clock);
		`CHK({regulatorOn, unitsOn, coilDriveEn}, 3'b000)
		host.pulse(3, 1'b0);
		`CHK(phase, 10'h000)
		standby = 1'b0;
		drive_enable_n = 1'b1;
		@(negedge clock);
		`CHK({phase, position}, 42'h0)
	endtask

	// Every resolution, all four fullstep values in turn
	task automatic tFullstep();
		int res[4] = '{8, 32, 64, 16};
		logic [9:0] exp;
		for (int c = 0; c < 4; c++) begin
			msSel = c[1:0];
			exp = 10'h080;
			for (int k = 0; k < 4; k++) begin
				host.pulse(k == 0 ? res[c] / 2 : res[c], 1'b0);
				`CHK({phase, fullstep}, {exp, 1'b1})
				exp += 10'h100;
			end
			doStandby();
		end
	endtask

	// Position recovery by replaying steps with the driver disabled
	task automatic tReplay();
		msSel = 2'h1;
		host.pulse(10, 1'b0);
		`CHK({phase, position}, {10'h050, 32'h0000000a})
		doStandby();
		host.pulse(10 % 128, 1'b0);
		`CHK(phase, 10'h050)
		drive_enable_n = 1'b0;
		#1 `CHK(coilDriveEn, 1'b1)
	endtask

	// Step down through zero, then park at a multiple of 128
	task automatic tWrap();
		doStandby();
		host.pulse(1, 1'b1);
		`CHK({phase, position}, {10'h3f8, 32'hffffffff})
		host.pulse(129, 1'b0);
		`CHK({phase, position}, {10'h000, 32'h00000080})
	endtask

	// Link: accepted write, corrupted write, then a read of the write counter
	task automatic tLink();
		logic [7:0] addr;
		logic [7:0] b;
		logic [63:0] reply;
		logic [55:0] exp;
		logic stopBit;
		addr = {6'h00, msSel};
		host.sendFrame({mcs_pkg::SYNC_BYTE, addr, 1'b1, mcs_pkg::REG_POSITION, 32'h12345678}, 7, 1'b0);
		`CHK(wrSeen, 1)
		`CHK(lastWr, {1'b1, mcs_pkg::REG_POSITION, 32'h12345678})
		`CHK({uartOeN, uartOut}, 2'b11)
		host.sendFrame({mcs_pkg::SYNC_BYTE, addr, 1'b1, mcs_pkg::REG_POSITION, 32'h0badf00d}, 7, 1'b1);
		// Idle long enough for the device to leave its recovery wait
		repeat (256) @(negedge clock);
		`CHK(wrSeen, 1)
		host.sendFrame({32'h00000000, mcs_pkg::SYNC_BYTE, addr, 1'b0, mcs_pkg::REG_WRCOUNT}, 3, 1'b0);
		reply = 64'h0;
		for (int i = 0; i < 8; i++) begin
			host.recvByte(b, stopBit);
			reply = {reply[55:0], b};
			`CHK({stopBit, uartOeN}, 2'b10)
		end
		exp = {mcs_pkg::SYNC_BYTE, mcs_pkg::REPLY_ADDR, 1'b0, mcs_pkg::REG_WRCOUNT, 32'h00000001};
		`CHK(reply, {exp, host.refCrc(exp, 7)})
		repeat (16) @(negedge clock);
		`CHK({uartOeN, uartOut}, 2'b11)
	endtask

	// Main sequence, with a second reset at the end
	initial begin
		rst = 1'b1;
		standby = 1'b0;
		drive_enable_n = 1'b1;
		msSel = 2'h0;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		tReset();
		tFullstep();
		tReplay();
		tWrap();
		tLink();
		rst = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		tReset();
		results();
	end
endmodule
